// *** rtl/pdh_pkg.sv ***
// Constants and types shared by the power-down hold block
package pdh_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Latest release of inputs after the sleep request rises, in ns
	localparam int unsigned RELEASE_MAX_NS = 5;
	// Longest recovery after the sleep request falls, in us
	localparam int unsigned WAKE_MAX_US = 2;
	// Longest time rounds down, never below one cycle
	localparam int unsigned RELEASE_CYC_RAW = RELEASE_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned RELEASE_CYC =
		(RELEASE_CYC_RAW < 1) ? 1 : RELEASE_CYC_RAW;
	localparam int unsigned WAKE_CYC = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_CNT_W = 8;
	localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST = 8'h00;

	typedef enum logic [2:0] {
		PDH_RUN = 3'h1,
		PDH_SLEEP = 3'h2,
		PDH_WAKE = 3'h4
	} pdh_mode_type;
endpackage

// *** rtl/pdh_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pdh_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} pdh_sync_state_type;

	pdh_sync_state_type st;
	pdh_sync_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = i_pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// First stage feeds only the second
		for (int i = 0; i < int'(WIDTH); i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.level[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_level = st.level;
endmodule
`default_nettype wire

// *** rtl/pdh_top.sv ***
// Pin-controlled power-down hold for a user I/O bank
// How it works
// - With the option on, a high sleep request pin enters power-down.
// - Outputs and internal state are frozen while powered down, except the pin synchroniser, which keeps sampling.
// - Outputs high-impedance at entry stay high-impedance throughout.
// - All inputs except the sleep request are ignored while down.
// - Pin hold latches keep the last input levels while down.
// - Option is build-time; sleep pin not fed to logic when chosen.
// - Inputs stop mattering within 5 ns of sleep request rising; here they are still sampled up to the fourth clock edge after.
// - Operation resumes within 2 us after sleep request falls; here it takes the sync delay plus WAKE_CYCLES, about 2.05 us at the default.
`timescale 1ns/1ps
`default_nettype none
module pdh_top
	import pdh_pkg::*;
#(
	parameter bit SLEEP_ENABLE = 1'b1,
	parameter int unsigned N_IO = 8,
	parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_sleep_request_pin,
	input wire logic [N_IO-1:0] i_pin,
	input wire logic [N_IO-1:0] i_core_out,
	input wire logic [N_IO-1:0] i_core_oe,
	output logic [N_IO-1:0] o_pin_out,
	output logic [N_IO-1:0] o_pin_oe,
	output logic [N_IO-1:0] o_core_in,
	output logic o_shared_in,
	output logic o_core_run,
	output logic o_asleep
);
	typedef struct packed {
		pdh_mode_type mode;
		logic [WAKE_CNT_W-1:0] wake_cnt;
		logic [N_IO-1:0] pin_out;
		logic [N_IO-1:0] pin_oe;
		logic [N_IO-1:0] core_in;
		logic shared_in;
		logic core_run;
		logic asleep;
	} pdh_state_type;

	pdh_state_type st;
	pdh_state_type next_st;
	logic [N_IO:0] sync_level;
	logic sleep_lvl;

	pdh_sync #(
		.WIDTH(N_IO + 1)
	) u_sync (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_pin({i_sleep_request_pin, i_pin}),
		.o_level(sync_level)
	);

	// Option fixed at build time, level ignored when off
	assign sleep_lvl = SLEEP_ENABLE ? sync_level[N_IO] : 1'b0;

	always_comb begin
		next_st = st;
		case (st.mode)
			PDH_RUN: begin
				// Sampling is live only in run mode
				next_st.core_in = sync_level[N_IO-1:0];
				next_st.pin_out = i_core_out;
				next_st.pin_oe = i_core_oe;
				next_st.core_run = 1'b1;
				next_st.asleep = 1'b0;
				if (sleep_lvl) begin
					// Freeze next edge, one cycle after the synchronised sleep level rises
					next_st.mode = PDH_SLEEP;
					next_st.core_run = 1'b0;
					next_st.asleep = 1'b1;
					next_st.pin_out = st.pin_out;
					next_st.pin_oe = st.pin_oe;
					next_st.core_in = st.core_in;
				end
			end
			PDH_SLEEP: begin
				// Outputs, enables and inputs held as captured
				// Core input latches keep last level
				next_st.core_run = 1'b0;
				next_st.asleep = 1'b1;
				if (!sleep_lvl) begin
					next_st.mode = PDH_WAKE;
					next_st.wake_cnt = WAKE_CNT_RST;
				end
			end
			PDH_WAKE: begin
				// Resume from held values, no reset
				next_st.wake_cnt = st.wake_cnt + 8'h01;
				if (sleep_lvl) begin
					next_st.mode = PDH_SLEEP;
				end else if (32'(st.wake_cnt) + 32'd1 >= WAKE_CYCLES
					|| st.wake_cnt == 8'hff) begin
					// Bounded recovery
					next_st.mode = PDH_RUN;
					next_st.asleep = 1'b0;
				end
			end
			default: begin
				next_st.mode = PDH_RUN;
			end
		endcase
		// Shared pin as plain input when option off
		next_st.shared_in = SLEEP_ENABLE ? 1'b0 : sync_level[N_IO];
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '{mode: PDH_RUN, wake_cnt: WAKE_CNT_RST, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign o_pin_out = st.pin_out;
	assign o_pin_oe = st.pin_oe;
	assign o_core_in = st.core_in;
	assign o_shared_in = st.shared_in;
	assign o_core_run = st.core_run;
	assign o_asleep = st.asleep;
endmodule
`default_nettype wire

// *** verif/pdh_sys_model.sv ***
// System logic driving the sleep pin and inputs
`timescale 1ns/1ps
`default_nettype none
module pdh_sys_model (
	input wire logic i_clk,
	input wire logic i_want,
	input wire logic [23:0] i_rnd,
	output logic o_sleep,
	output logic [23:0] o_drive
);
	int n = 0;
	initial o_sleep = 0;
	initial o_drive = 0;
	always @(posedge i_clk) begin
		#1;
		n = i_want ? ((n < 3) ? n + 1 : n) : 0;
		o_sleep = (n >= 2); // Inputs frozen a cycle first
		if (n < 1 || n > 2) // No change near the rise
			o_drive = i_rnd;
	end
endmodule
`default_nettype wire

// *** verif/pdh_top_asserts.sv ***
// Power-down hold checks
`timescale 1ns/1ps
`default_nettype none
module pdh_top_asserts #(
	parameter int unsigned N_IO = 8
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_sleep_request_pin,
	input wire logic [N_IO-1:0] i_core_out,
	input wire logic [N_IO-1:0] o_pin_out,
	input wire logic [N_IO-1:0] o_pin_oe,
	input wire logic [N_IO-1:0] o_core_in,
	input wire logic o_shared_in,
	input wire logic o_core_run,
	input wire logic o_asleep
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	a_hold_out: assert property (o_asleep && $past(o_asleep)
		|-> $stable(o_pin_out)) else $error("out moved");
	a_hold_oe: assert property (o_asleep && $past(o_asleep)
		|-> $stable(o_pin_oe)) else $error("oe moved");
	a_hold_in: assert property (o_asleep && $past(o_asleep)
		|-> $stable(o_core_in)) else $error("in moved");
	a_run_off: assert property (o_asleep |-> !o_core_run)
		else $error("run in sleep");
	a_shared_zero: assert property (!o_shared_in)
		else $error("shared pin seen");
	a_enter_sleep: assert property ($rose(i_sleep_request_pin)
		##0 i_sleep_request_pin[*6] |-> o_asleep) else $error("late sleep");
	// Bounds assume WAKE_CYCLES of 4
	a_wake_bound: assert property ($fell(i_sleep_request_pin)
		##0 (!i_sleep_request_pin)[*8] |-> ##[0:8] !o_asleep)
		else $error("late wake");
	a_run_resume: assert property ($fell(o_asleep) |-> ##1 o_core_run)
		else $error("no resume");
	a_out_follow: assert property (o_core_run && $past(o_core_run)
		|-> o_pin_out == $past(i_core_out)) else $error("out stuck");
endmodule
bind pdh_top pdh_top_asserts #(.N_IO(N_IO)) chk (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the power-down hold block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_mclk = 0;
	logic i_arst_n = 0;
	logic want = 0;
	logic [23:0] rnd = 0;
	logic [23:0] drv, held;
	logic [7:0] p_out, p_oe, c_in;
	logic slp, run, asl, shr;
	int bad_count = 0, check_count = 0, seed = 66, cyc = 0;
	initial forever #5 i_mclk = ~i_mclk;
	pdh_sys_model sys (.i_clk(i_mclk), .i_want(want), .i_rnd(rnd),
		.o_sleep(slp), .o_drive(drv));
	pdh_top #(.WAKE_CYCLES(4)) DUT (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_sleep_request_pin(slp), .i_pin(drv[7:0]),
		.i_core_out(drv[15:8]), .i_core_oe(drv[23:16]), .o_pin_out(p_out),
		.o_pin_oe(p_oe), .o_core_in(c_in), .o_shared_in(shr),
		.o_core_run(run), .o_asleep(asl));
	function automatic logic [23:0] exp_live(input logic [23:0] d);
		return d; // Outputs mirror the live drive
	endfunction
	task automatic check(input string what, input logic [23:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wait_asl(input logic lvl);
		for (int w = 0; w < 30 && asl !== lvl; w++) begin
			@(posedge i_mclk);
			#2;
		end
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		repeat (5) @(posedge i_mclk);
		#2 i_arst_n = 1;
		for (int k = 0; k < 12; k++) begin
			// First pass: every output high-Z at entry
			rnd = (k == 0) ? 24'h00a5ff : 24'($random(seed));
			repeat (8) @(posedge i_mclk);
			#2 check("live", {p_oe, p_out, c_in}, exp_live(rnd));
			want = 1;
			wait_asl(1'b1);
			check("asleep", 24'(asl), 24'h000001);
			held = {p_oe, p_out, c_in};
			repeat (20) begin
				@(posedge i_mclk);
				#2 rnd = 24'($random(seed));
			end
			check("held", {p_oe, p_out, c_in}, held);
			want = 0;
			wait_asl(1'b0);
			@(posedge i_mclk);
			#2 check("run", 24'(run), 24'h000001);
			check("shared", 24'(shr), 24'h000000);
		end
		test_done();
	end
endmodule
`default_nettype wire
